//--- swcf_config.sv
// Two-wire interface configuration register, bus-busy tracking and timeout support
`timescale 1ns/1ps
`include "swcf_map.svh"

module swcf_config
  import swcf_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic t0_overflow,
  input wire logic t1_overflow,
  input wire logic t2_high_overflow,
  input wire logic t2_low_overflow,
  input wire logic timer3_split,
  input wire logic master_mode,
  input wire logic start_request,
  input wire logic slave_event,
  input wire logic master_event,
  input wire logic address_received,
  output logic bitrate_tick,
  output logic t3_reload_high,
  output logic t3_reload_low,
  output logic slave_irq,
  output logic master_irq,
  output logic address_nack,
  output logic start_generate,
  output logic hold_time_extension,
  output logic [3:0] setup_min_clocks,
  output logic [3:0] hold_min_clocks
);
  logic [1:0] line_s;
  logic scl_s, sda_s, scl_prev_q, sda_prev_q;
  logic enable_q, inhibit_q, inhibit_eff_q, hold_time_extension_q, lowtmo_q, freetmo_q;
  swcf_src_t src_q;
  swcf_bus_t bus_q;
  logic [3:0] free_cnt_q;
  logic start_det, stop_det, src_tick, src_used, free_hit;
  logic [7:0] cfg_view;

  // ----------------------------------------------------------------
  // Line sampling
  // ----------------------------------------------------------------
  swcf_sync #(.WIDTH(2)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .sync_out(line_s)
  );
  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Conditions are only seen while enabled and watched every cycle
  assign start_det = enable_q && scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = enable_q && scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_q <= 1'b0;
      inhibit_q <= 1'b0;
      hold_time_extension_q <= 1'b0;
      lowtmo_q <= 1'b0;
      freetmo_q <= 1'b0;
      src_q <= SWCF_SRC_T0;
    end else if (sfr_wr && sfr_addr == `SWCF_CFG_ADDR) begin
      // Busy position is not stored from the bus
      enable_q <= sfr_wdata[`SWCF_BIT_ENABLE];
      inhibit_q <= sfr_wdata[`SWCF_BIT_INHIBIT];
      hold_time_extension_q <= sfr_wdata[`SWCF_BIT_HOLD_TIME_EXTENSION];
      lowtmo_q <= sfr_wdata[`SWCF_BIT_LOWTMO];
      freetmo_q <= sfr_wdata[`SWCF_BIT_FREETMO];
      src_q <= swcf_src_t'(sfr_wdata[`SWCF_SRC_HI:`SWCF_SRC_LO]);
    end
  end

  always_comb begin
    cfg_view = `SWCF_CFG_RESET;
    cfg_view[`SWCF_BIT_ENABLE] = enable_q;
    cfg_view[`SWCF_BIT_INHIBIT] = inhibit_q;
    cfg_view[`SWCF_BIT_BUSY] = (bus_q == SWCF_BUS_OCCUPIED);
    cfg_view[`SWCF_BIT_HOLD_TIME_EXTENSION] = hold_time_extension_q;
    cfg_view[`SWCF_BIT_LOWTMO] = lowtmo_q;
    cfg_view[`SWCF_BIT_FREETMO] = freetmo_q;
    cfg_view[`SWCF_SRC_HI:`SWCF_SRC_LO] = src_q;
  end

  // Read data held until the next read of any address
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `SWCF_CFG_ADDR) begin
        sfr_rdata <= cfg_view;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  always_comb begin
    case (src_q)
      SWCF_SRC_T0: src_tick = t0_overflow;
      SWCF_SRC_T1: src_tick = t1_overflow;
      SWCF_SRC_T2_HIGH: src_tick = t2_high_overflow;
      default: src_tick = t2_low_overflow;
    endcase
  end
  // Slave-only use still needs the source for the free timeout
  assign src_used = enable_q && (master_mode || freetmo_q);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bitrate_tick <= 1'b0;
    end else begin
      bitrate_tick <= src_used && src_tick;
    end
  end

  // ----------------------------------------------------------------
  // Free-bus timeout and busy state
  // ----------------------------------------------------------------
  // Eleventh whole period of both lines high means more than ten
  assign free_hit = enable_q && freetmo_q && scl_s && sda_s && src_tick
    && free_cnt_q == `SWCF_FREE_PERIODS;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      free_cnt_q <= 4'h0;
    end else if (!(enable_q && freetmo_q && scl_s && sda_s) || free_hit) begin
      free_cnt_q <= 4'h0;
    end else if (src_tick && free_cnt_q != `SWCF_FREE_PERIODS) begin
      free_cnt_q <= free_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_q <= SWCF_BUS_FREE;
    end else begin
      case (bus_q)
        SWCF_BUS_FREE: begin
          if (start_det) begin
            bus_q <= SWCF_BUS_OCCUPIED;
          end
        end
        default: begin
          if (!enable_q || stop_det || free_hit) begin
            bus_q <= SWCF_BUS_FREE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start_generate <= 1'b0;
    end else begin
      start_generate <= start_request && bus_q == SWCF_BUS_OCCUPIED && free_hit;
    end
  end

  // ----------------------------------------------------------------
  // Slave inhibit and interrupts
  // ----------------------------------------------------------------
  // A transfer already running keeps its interrupts until a new START
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inhibit_eff_q <= 1'b0;
    end else if (start_det || bus_q == SWCF_BUS_FREE) begin
      inhibit_eff_q <= inhibit_q;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slave_irq <= 1'b0;
      master_irq <= 1'b0;
      address_nack <= 1'b0;
    end else begin
      slave_irq <= enable_q && slave_event && !inhibit_eff_q;
      master_irq <= enable_q && master_event;
      address_nack <= enable_q && address_received && inhibit_eff_q;
    end
  end

  // ----------------------------------------------------------------
  // Timer 3 control and SDA timing
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      t3_reload_high <= 1'b0;
      t3_reload_low <= 1'b0;
    end else begin
      t3_reload_high <= enable_q && lowtmo_q && scl_s;
      t3_reload_low <= enable_q && lowtmo_q && scl_s && !timer3_split;
    end
  end

  // Normal setup also depends on the low time, so only its floor is given
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_time_extension <= 1'b0;
      setup_min_clocks <= `SWCF_SETUP_NORMAL;
      hold_min_clocks <= `SWCF_HOLD_NORMAL;
    end else begin
      hold_time_extension <= hold_time_extension_q;
      setup_min_clocks <= hold_time_extension_q ? `SWCF_SETUP_EXT : `SWCF_SETUP_NORMAL;
      hold_min_clocks <= hold_time_extension_q ? `SWCF_HOLD_EXT : `SWCF_HOLD_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_start_seen;
    start_det ##1 (bus_q == SWCF_BUS_OCCUPIED);
  endsequence

  a_disabled_quiet: assert property (!enable_q |=> !slave_irq && !master_irq)
    else $error("interrupt while interface disabled");
  a_busy_on_start: assert property (start_det |-> s_start_seen)
    else $error("busy not set after start");
  a_busy_on_stop: assert property (stop_det |=> bus_q == SWCF_BUS_FREE)
    else $error("busy not cleared after stop");
  a_free_expire: assert property (free_hit |=> bus_q == SWCF_BUS_FREE && free_cnt_q == 4'h0)
    else $error("free timeout did not release bus");
  a_t3_reload: assert property (enable_q && lowtmo_q && scl_s |=> t3_reload_high)
    else $error("timer 3 not held in reload");
  a_t3_split: assert property (timer3_split |=> !t3_reload_low)
    else $error("split low half forced to reload");
  a_slave_block: assert property (inhibit_eff_q && slave_event |=> !slave_irq)
    else $error("slave interrupt while inhibited");
  a_master_pass: assert property (enable_q && master_event |=> master_irq)
    else $error("master interrupt lost");
  a_nack_addr: assert property (enable_q && inhibit_eff_q && address_received |=> address_nack)
    else $error("address not refused while inhibited");
  a_start_gen: assert property (start_request && bus_q == SWCF_BUS_OCCUPIED && free_hit
    |=> start_generate)
    else $error("pending start not generated");
  a_src_tick: assert property (src_used && src_q == SWCF_SRC_T2_LOW && t2_low_overflow
    |=> bitrate_tick)
    else $error("selected source tick missing");
  a_inhibit_hold: assert property (bus_q == SWCF_BUS_OCCUPIED && !start_det
    |=> $stable(inhibit_eff_q))
    else $error("inhibit changed mid transfer");
  a_hold_ext: assert property (hold_time_extension_q |=> hold_min_clocks == `SWCF_HOLD_EXT)
    else $error("extended hold not selected");
endmodule // swcf_config

//--- swcf_map.svh
// Register map, field positions, reset values and timing counts of the two-wire configuration
`ifndef SWCF_MAP_SVH
`define SWCF_MAP_SVH
`define SWCF_CFG_ADDR 8'hc1
`define SWCF_CFG_RESET 8'h00
`define SWCF_BIT_ENABLE 7
`define SWCF_BIT_INHIBIT 6
`define SWCF_BIT_BUSY 5
`define SWCF_BIT_HOLD_TIME_EXTENSION 4
`define SWCF_BIT_LOWTMO 3
`define SWCF_BIT_FREETMO 2
`define SWCF_SRC_HI 1
`define SWCF_SRC_LO 0
`define SWCF_FREE_PERIODS 4'ha
`define SWCF_HOLD_NORMAL 4'h3
`define SWCF_HOLD_EXT 4'hc
`define SWCF_SETUP_NORMAL 4'h1
`define SWCF_SETUP_EXT 4'hb
`endif

//--- swcf_pkg.sv
// Types shared by the two-wire configuration block
package swcf_pkg;
  typedef enum logic [1:0] {
    SWCF_SRC_T0,
    SWCF_SRC_T1,
    SWCF_SRC_T2_HIGH,
    SWCF_SRC_T2_LOW
  } swcf_src_t;
  typedef enum logic {
    SWCF_BUS_FREE,
    SWCF_BUS_OCCUPIED
  } swcf_bus_t;
endpackage

//--- swcf_sync.sv
// Two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ps
module swcf_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // swcf_sync

//--- swcf_bus_model.sv
// Far-side bus party: drives the SCL and SDA levels seen by the block
`timescale 1ns/1ps
module swcf_bus_model (
  output logic scl,
  output logic sda
);
  // Released lines rest high on the pull-ups; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start_cond();
    sda = 1'b0;
    #80;
    scl = 1'b0;
    #80;
  endtask
  task automatic stop_cond();
    sda = 1'b0;
    #80;
    scl = 1'b1;
    #80;
    sda = 1'b1;
    #80;
  endtask
  // Both lines end high without a STOP, so only the free timeout or clearing the enable bit can end the transfer
  task automatic abandon();
    sda = 1'b1;
    #80;
    scl = 1'b1;
    #80;
  endtask
  task automatic hold_scl(input logic lvl);
    scl = lvl;
    #160;
  endtask
endmodule // swcf_bus_model

//--- testbench.sv
// Self-checking bench for the two-wire configuration block
`timescale 1ns/1ps
module testbench;
  import swcf_pkg::*;
  logic clock, sys_rst, sfr_wr, sfr_rd, t0_overflow, t1_overflow, t2_high_overflow;
  logic t2_low_overflow, timer3_split, master_mode, start_request, slave_event;
  logic master_event, address_received, bitrate_tick, t3_reload_high, t3_reload_low;
  logic slave_irq, master_irq, address_nack, start_generate, hold_time_extension;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] setup_min_clocks, hold_min_clocks;
  logic scl, sda;
  int bad_count = 0;
  int n_checks = 0;
  swcf_bus_model bus (.scl(scl), .sda(sda));
  swcf_config DUT (.clock, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .scl_in(scl), .sda_in(sda), .t0_overflow, .t1_overflow, .t2_high_overflow,
    .t2_low_overflow, .timer3_split, .master_mode, .start_request, .slave_event,
    .master_event, .address_received, .bitrate_tick, .t3_reload_high, .t3_reload_low,
    .slave_irq, .master_irq, .address_nack, .start_generate, .hold_time_extension,
    .setup_min_clocks, .hold_min_clocks);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    // Idle edge keeps back-to-back write strobes apart
    tick(1);
  endtask
  // Two edges pass so the registered read data has landed whatever its exact latency
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    tick(1);
    check("sfr_rdata", sfr_rdata, exp);
  endtask
  task automatic ovf(input int k);
    {t2_low_overflow, t2_high_overflow, t1_overflow, t0_overflow} = 4'h1 << k;
    tick(1);
    {t2_low_overflow, t2_high_overflow, t1_overflow, t0_overflow} = 4'h0;
  endtask
  task automatic ev(input logic [2:0] v, input logic [2:0] exp);
    {slave_event, master_event, address_received} = v;
    tick(1);
    {slave_event, master_event, address_received} = 3'h0;
    check("irq_nack", {5'h00, slave_irq, master_irq, address_nack}, {5'h00, exp});
    tick(1);
  endtask
  task automatic t_regs();
    rd(8'hc1, 8'h00);
    check("setup", setup_min_clocks, 8'h01);
    check("hold", hold_min_clocks, 8'h03);
    wr(8'hc1, 8'hff);
    wr(8'hc2, 8'h00);
    rd(8'hc1, 8'hdf);
    rd(8'hc2, 8'h00);
    check("ext", hold_time_extension, 8'h01);
    check("setup_ext", setup_min_clocks, 8'h0b);
    check("hold_ext", hold_min_clocks, 8'h0c);
    wr(8'hc1, 8'h00);
    tick(1);
    check("hold_norm", hold_min_clocks, 8'h03);
    $display("test regs done");
  endtask
  task automatic t_src();
    for (int s = 0; s < 4; s++) begin
      master_mode = 1'b1;
      wr(8'hc1, 8'h80 | 8'(s));
      for (int k = 0; k < 4; k++) begin
        ovf(k);
        check("bitrate_tick", bitrate_tick, (k == s) ? 8'h01 : 8'h00);
        tick(1);
      end
      master_mode = 1'b0;
      ovf(s);
      check("tick_idle", bitrate_tick, 8'h00);
      wr(8'hc1, 8'h84 | 8'(s));
      ovf(s);
      check("tick_free", bitrate_tick, 8'h01);
    end
    $display("test source done");
  endtask
  task automatic t_busy();
    wr(8'hc1, 8'h80);
    bus.start_cond();
    tick(3);
    rd(8'hc1, 8'ha0);
    bus.stop_cond();
    tick(3);
    rd(8'hc1, 8'h80);
    wr(8'hc1, 8'h00);
    bus.start_cond();
    tick(3);
    rd(8'hc1, 8'h00);
    bus.stop_cond();
    $display("test busy done");
  endtask
  task automatic t_free();
    int i;
    wr(8'hc1, 8'h84);
    start_request = 1'b1;
    bus.start_cond();
    bus.abandon();
    tick(3);
    repeat (10) begin
      ovf(0);
      tick(1);
    end
    tick(2);
    check("early_start", start_generate, 8'h00);
    rd(8'hc1, 8'ha4);
    ovf(0);
    for (i = 0; i < 4 && start_generate !== 1'b1; i++) tick(1);
    check("start_generate", start_generate, 8'h01);
    if (i == 4) tally_and_finish();
    start_request = 1'b0;
    rd(8'hc1, 8'h84);
    $display("test free timeout done");
  endtask
  task automatic t_inhibit();
    wr(8'hc1, 8'h80);
    ev(3'b100, 3'b100);
    wr(8'hc1, 8'hc0);
    tick(1);
    ev(3'b100, 3'b000);
    ev(3'b010, 3'b010);
    ev(3'b001, 3'b001);
    wr(8'hc1, 8'h80);
    bus.start_cond();
    tick(3);
    wr(8'hc1, 8'hc0);
    ev(3'b100, 3'b100);
    bus.stop_cond();
    bus.start_cond();
    tick(3);
    ev(3'b100, 3'b000);
    bus.stop_cond();
    $display("test inhibit done");
  endtask
  task automatic t_timer3();
    wr(8'hc1, 8'h88);
    tick(4);
    check("t3_reload", {t3_reload_high, t3_reload_low}, 8'h03);
    bus.hold_scl(1'b0);
    tick(1);
    check("t3_count", {t3_reload_high, t3_reload_low}, 8'h00);
    timer3_split = 1'b1;
    bus.hold_scl(1'b1);
    tick(1);
    check("t3_split", {t3_reload_high, t3_reload_low}, 8'h02);
    $display("test timer3 done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {sfr_wr, sfr_rd, timer3_split, master_mode, start_request} = 5'h00;
    {slave_event, master_event, address_received} = 3'h0;
    {t2_low_overflow, t2_high_overflow, t1_overflow, t0_overflow} = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    t_regs();
    t_src();
    t_busy();
    t_free();
    t_inhibit();
    t_timer3();
    tally_and_finish();
  end
endmodule // testbench
